// *** hdl/spr_top.sv ***
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "spr_regs.svh"
// Overview of operation
// - start low, eight data, stop high
// - nrz or biphase line format
// - biphase receive tolerates 25% slow drift
// - four software selectable bit rates
// - rate code divides bus clock 16..4096
// - bit time is divisor times period
// - format field picks format and clock
// - external party may supply bit clock
// - shared pin free as clock input
// - dedicated tx/rx pins, hardware framing
// - idle transmit line held high
// - least significant bit sent first
module spr_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial data pins
  output logic             ser_txd,
  input  wire logic        ser_rxd,
  // shared clock pin
  input  wire logic        ser_clk_i,
  output logic             ser_clk_o,
  output logic             ser_clk_oe
);
  import spr_pkg::*;
  localparam logic [12:0] DIV0 = 13'(`SPR_DIV0);
  localparam logic [12:0] DIV1 = 13'(`SPR_DIV1);
  localparam logic [12:0] DIV2 = 13'(`SPR_DIV2);
  localparam logic [12:0] DIV3 = 13'(`SPR_DIV3);
  // ===================================================================
  // register bus
  logic [3:0]  ctrl_r;
  logic [7:0]  txdata_r;
  logic        tx_go_r;
  logic        rx_full_r;
  logic        ferr_r;
  logic        ovr_r;
  logic [7:0]  rxdata_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_ofs_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        wr_fire;
  logic        rd_fire;
  logic        tx_busy;
  logic [3:0]  rd_ofs;
  spr_cfg_t    cfg;
  spr_rx_t     rx;
  assign cfg = spr_cfg_t'(ctrl_r);
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_r && w_got_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  // addresses past the map fold onto an unaligned code, which decodes as unmapped
  assign rd_ofs  = (s_axi_araddr[31:4] == 28'h0) ? s_axi_araddr[3:0] : 4'h1;
  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_ofs_r <= 4'h0;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_ofs_r <= (s_axi_awaddr[31:4] == 28'h0) ? s_axi_awaddr[3:0] : 4'h1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r    <= s_axi_wdata;
        ws_r    <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end
  // write response; unmapped writes answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_ofs_r == `SPR_CTRL_OFS || aw_ofs_r == `SPR_TXDATA_OFS)
                      ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // control and transmit data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= `SPR_CTRL_RESET;
      txdata_r <= 8'h00;
      tx_go_r  <= 1'b0;
    end else begin
      tx_go_r <= 1'b0;
      if (wr_fire && ws_r[0]) begin
        if (aw_ofs_r == `SPR_CTRL_OFS) ctrl_r <= wd_r[3:0];
        if (aw_ofs_r == `SPR_TXDATA_OFS && !tx_busy) begin
          txdata_r <= wd_r[7:0];
          tx_go_r  <= 1'b1; // write while busy is dropped
        end
      end
    end
  end
  // receive flags: a new byte wins over the read that clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_r <= 1'b0;
      ferr_r    <= 1'b0;
      ovr_r     <= 1'b0;
      rxdata_r  <= 8'h00;
    end else begin
      if (rd_fire && rd_ofs == `SPR_RXDATA_OFS) begin
        rx_full_r <= 1'b0;
        ferr_r    <= 1'b0;
        ovr_r     <= 1'b0;
      end
      if (rx.valid) begin
        rx_full_r <= 1'b1;
        rxdata_r  <= rx.data;
        ferr_r    <= rx.frame_err;
        ovr_r     <= rx_full_r && !(rd_fire && rd_ofs == `SPR_RXDATA_OFS);
      end
    end
  end
  // read channel, one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      unique case (rd_ofs)
        `SPR_CTRL_OFS:   s_axi_rdata <= {28'h0, ctrl_r};
        `SPR_TXDATA_OFS: s_axi_rdata <= {24'h0, txdata_r};
        `SPR_STATUS_OFS: s_axi_rdata <= {28'h0, ovr_r, ferr_r, rx_full_r, tx_busy};
        `SPR_RXDATA_OFS: s_axi_rdata <= {24'h0, rxdata_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ===================================================================
  // bit clock generation
  logic [12:0] div_cnt_r;
  logic [12:0] div_sel;
  logic        int_half;
  logic        int_samp;
  logic [1:0]  clk_sync_r;
  logic        clk_prev_r;
  logic        ext_rise;
  logic [3:0]  ext_cnt_r;
  logic        ext_half;
  logic        use_ext;
  logic        half_tick;
  logic        samp_tick;
  logic [1:0]  rxd_sync_r;
  // divisor of the bus clock; bit time = divisor x period
  always_comb begin
    unique case (cfg.rate)
      2'b00: div_sel = DIV0;
      2'b01: div_sel = DIV1;
      2'b10: div_sel = DIV2;
      2'b11: div_sel = DIV3;
    endcase
  end
  // free-running counter; rate change only affects tick spacing
  always_ff @(posedge aclk) begin
    if (!aresetn) div_cnt_r <= 13'h0000;
    else if (div_cnt_r >= div_sel - 13'h0001) div_cnt_r <= 13'h0000;
    else div_cnt_r <= div_cnt_r + 13'h0001;
  end
  assign int_half = (div_cnt_r == 13'h0000) || (div_cnt_r == (div_sel >> 1));
  // sixteen samples per bit: one every divisor/16 cycles
  assign int_samp = ((div_cnt_r & ((div_sel >> 4) - 13'h0001)) == 13'h0000);
  // external clock pin: two flops, then edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sync_r <= 2'b00;
      clk_prev_r <= 1'b0;
      rxd_sync_r <= 2'b11;
      ext_cnt_r  <= 4'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[0], ser_clk_i};
      clk_prev_r <= clk_sync_r[1];
      rxd_sync_r <= {rxd_sync_r[0], ser_rxd};
      if (ext_rise) ext_cnt_r <= ext_cnt_r + 4'h1;
    end
  end
  // external clock is sixteen samples per bit
  assign ext_rise  = clk_sync_r[1] && !clk_prev_r;
  assign ext_half  = ext_rise && (ext_cnt_r[2:0] == 3'h7);
  assign use_ext   = (cfg.fmt == SPR_FMT_NRZ_CKI);
  assign half_tick = use_ext ? ext_half : int_half;
  assign samp_tick = use_ext ? ext_rise : int_samp;
  // bit clock out on the shared pin only in code 10; otherwise pin is input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_clk_o  <= 1'b0;
      ser_clk_oe <= 1'b0;
    end else begin
      ser_clk_oe <= (cfg.fmt == SPR_FMT_NRZ_CKO);
      ser_clk_o  <= (div_cnt_r < (div_sel >> 1));
    end
  end
  // ===================================================================
  // framers
  spr_tx u_tx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .half_tick (half_tick),
    .cfg       (cfg),
    .start     (tx_go_r),
    .data      (txdata_r),
    .busy      (tx_busy),
    .txd       (ser_txd)
  );
  spr_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .samp_tick (samp_tick),
    .cfg       (cfg),
    .rxd       (rxd_sync_r[1]),
    .rx        (rx)
  );
endmodule

// *** pkg/spr_regs.svh ***
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH
// register map
`define SPR_ADDR_W        4
`define SPR_CTRL_OFS      4'h0
`define SPR_TXDATA_OFS    4'h4
`define SPR_STATUS_OFS    4'h8
`define SPR_RXDATA_OFS    4'hC
// control field positions and reset
`define SPR_CTRL_RATE_LSB 0
`define SPR_CTRL_FMT_LSB  2
`define SPR_CTRL_RESET    4'h1
// status bits
`define SPR_ST_TX_BUSY    0
`define SPR_ST_RX_FULL    1
`define SPR_ST_FRAME_ERR  2
`define SPR_ST_OVERRUN    3
// divisors of the bus clock for rate codes 0..3
`define SPR_DIV0          16
`define SPR_DIV1          128
`define SPR_DIV2          1024
`define SPR_DIV3          4096
// external clock samples per bit
`define SPR_OVS           16
`endif

// *** pkg/spr_pkg.sv ***
package spr_pkg;
  typedef enum logic [1:0] {
    SPR_FMT_BIPHASE  = 2'b00,
    SPR_FMT_NRZ      = 2'b01,
    SPR_FMT_NRZ_CKO  = 2'b10,
    SPR_FMT_NRZ_CKI  = 2'b11
  } spr_fmt_t;
  typedef struct packed {
    spr_fmt_t   fmt;
    logic [1:0] rate;
  } spr_cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       frame_err;
  } spr_rx_t;
endpackage

// *** hdl/spr_tx.sv ***
`timescale 1ns/100ps
`include "spr_regs.svh"
module spr_tx (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // timing
  input  wire logic              half_tick,
  input  wire spr_pkg::spr_cfg_t cfg,
  // byte in
  input  wire logic              start,
  input  wire logic [7:0]        data,
  output logic                   busy,
  // line
  output logic                   txd
);
  import spr_pkg::*;
  typedef enum {TX_IDLE, TX_RUN} spr_txst_t;
  spr_txst_t  st_r;
  logic [9:0] sh_r;
  logic [3:0] cnt_r;
  logic       half_r;
  logic       bip_r;
  logic       lvl_r;
  assign busy = (st_r != TX_IDLE) | start;
  // frame of start, eight data lsb first, stop, on half-bit ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= TX_IDLE;
      sh_r   <= 10'h3FF;
      cnt_r  <= 4'h0;
      half_r <= 1'b0;
      bip_r  <= 1'b0;
      lvl_r  <= 1'b1;
      txd    <= 1'b1;
    end else begin
      unique case (st_r)
        TX_IDLE: begin
          txd <= 1'b1; // idle line is high
          if (start) begin
            sh_r   <= {1'b1, data, 1'b0};
            bip_r  <= (cfg.fmt == SPR_FMT_BIPHASE); // latched per frame
            cnt_r  <= 4'h0;
            half_r <= 1'b0;
            lvl_r  <= 1'b1;
            st_r   <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (half_tick && !half_r && cnt_r == 4'd10) begin
            // full stop cell done; back to mark
            txd  <= 1'b1;
            st_r <= TX_IDLE;
          end else if (half_tick) begin
            if (!bip_r) begin
              if (!half_r) txd <= sh_r[0];
            end else if (!half_r) begin
              // biphase: flip at every cell edge
              lvl_r <= ~lvl_r;
              txd   <= ~lvl_r;
            end else if (sh_r[0]) begin
              // extra mid-cell flip marks a one
              lvl_r <= ~lvl_r;
              txd   <= ~lvl_r;
            end
            half_r <= ~half_r;
            if (half_r) begin
              sh_r  <= {1'b1, sh_r[9:1]};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
      endcase
    end
  end
endmodule

// *** hdl/spr_rx.sv ***
`timescale 1ns/100ps
`include "spr_regs.svh"
module spr_rx (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // timing: sixteen samples per bit
  input  wire logic              samp_tick,
  input  wire spr_pkg::spr_cfg_t cfg,
  // line, already synchronised
  input  wire logic              rxd,
  // byte out
  output spr_pkg::spr_rx_t       rx
);
  import spr_pkg::*;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} spr_rxst_t;
  spr_rxst_t  st_r;
  logic [4:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic       bip_r;
  logic       prev_r;
  logic       cell_r;
  logic       mid_r;
  // nrz samples mid-bit; biphase decodes edges with a moving window,
  // resyncing on every cell edge so slow drift of the sender is absorbed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= RX_IDLE;
      ph_r   <= 5'h00;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      bip_r  <= 1'b0;
      prev_r <= 1'b1;
      cell_r <= 1'b0;
      mid_r  <= 1'b0;
      rx     <= '0;
    end else begin
      rx.valid <= 1'b0;
      if (samp_tick) begin
        prev_r <= rxd;
        ph_r   <= ph_r + 5'h01;
        unique case (st_r)
          RX_IDLE: begin
            if (prev_r && !rxd) begin
              bip_r <= (cfg.fmt == SPR_FMT_BIPHASE);
              ph_r  <= 5'h00;
              st_r  <= RX_START;
            end
          end
          RX_START: begin
            if (!bip_r && ph_r == 5'd7) begin
              ph_r  <= 5'h01; // first data close must not shift a stale cell
              bit_r <= 4'h0;
              st_r  <= rxd ? RX_IDLE : RX_DATA; // start bit is low
            end else if (bip_r && ((rxd != prev_r && ph_r > 5'd11) || ph_r == 5'd24)) begin
              // start cell has no mid flip; data cells begin at its closing edge
              ph_r  <= 5'h01;
              bit_r <= 4'h0;
              mid_r <= 1'b0;
              st_r  <= RX_DATA;
            end
          end
          RX_DATA, RX_STOP: begin
            if (!bip_r) begin
              if (ph_r == 5'd15) begin
                ph_r <= 5'h00;
                cell_r <= rxd;
              end
            end else begin
              // window 25% to 75% of cell counts as mid; later edge is boundary
              if (rxd != prev_r && ph_r >= 5'd4 && ph_r <= 5'd11) begin
                mid_r <= 1'b1;
              end else if (rxd != prev_r && ph_r > 5'd11) begin
                ph_r   <= 5'h00;
                cell_r <= mid_r;
                mid_r  <= 1'b0;
              end else if (ph_r == 5'd24) begin
                ph_r   <= 5'h00; // lost edge: close cell anyway
                cell_r <= mid_r;
                mid_r  <= 1'b0;
              end
            end
          end
          default: st_r <= RX_IDLE;
        endcase
      end
      // bit count advances one sample tick after the cell is sampled; shift and output come two ticks after
      if (samp_tick && ph_r == 5'h00 && (st_r == RX_DATA || st_r == RX_STOP)
          && bit_r != 4'hF) begin
        bit_r <= bit_r + 4'h1;
      end
      if (st_r == RX_DATA && bit_r != 4'h0 && bit_r <= 4'd8 && ph_r == 5'h01
          && samp_tick) begin
        sh_r <= {cell_r, sh_r[7:1]}; // lsb first
        if (bit_r == 4'd8) st_r <= RX_STOP;
      end
      if (st_r == RX_STOP && bit_r == 4'd9 && ph_r == 5'h01 && samp_tick) begin
        rx.valid     <= 1'b1;
        rx.data      <= sh_r;
        rx.frame_err <= !cell_r; // stop bit must be high
        st_r         <= RX_IDLE;
      end
    end
  end
endmodule

// *** bench/spr_chk.sv ***
`timescale 1ns/100ps
module spr_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial pins
  input wire logic        ser_txd,
  input wire logic        ser_clk_oe
);
  // all checks run on the bus clock and rest during reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_both;
  // address and data taken on one edge
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // ==========================================
  // register bus timing
  wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write not answered in two cycles");
  bad_wr_a: assert property (wr_both && s_axi_awaddr[31:4] != 0 |-> ##2 s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  bad_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:4] != 0
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  // ==========================================
  // line shape: no pulse shorter than half of the fastest bit cell
  idle_out_a: assert property ($rose(aresetn) |-> ser_txd && !ser_clk_oe)
    else $error("line not idle after reset");
  low_min_a: assert property ($fell(ser_txd) |-> !ser_txd [*8])
    else $error("low pulse too short");
  high_min_a: assert property ($rose(ser_txd) |-> ser_txd [*8])
    else $error("high pulse too short");
endmodule
bind spr_top spr_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ser_txd(ser_txd),
  .ser_clk_oe(ser_clk_oe)
);

// *** bench/spr_far.sv ***
`timescale 1ns/100ps
module spr_far (
  // clock
  input  wire logic aclk,
  // lines
  input  wire logic txd,
  output logic      rxd
);
  localparam int B = 16; // cycles per bit at rate code 00
  // remote line rests at mark
  initial rxd = 1'b1;
  // decode a character; biphase one is a level change across mid-cell
  task automatic recv(input logic bph, output logic [9:0] f);
    logic a;
    @(negedge txd);
    for (int i = 0; i < 10; i++) begin
      repeat (B/4) @(posedge aclk);
      a = txd;
      repeat (B/2) @(posedge aclk);
      f[i] = bph ? a ^ txd : a;
      repeat (B/4) @(posedge aclk);
    end
  endtask
  // send a character; len other than B models a drifting remote clock
  task automatic send(input logic bph, input int len, input logic [7:0] d);
    logic [9:0] f;
    logic       lvl;
    f = {1'b1, d, 1'b0};
    lvl = 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      lvl = bph ? !lvl : f[i];
      rxd <= lvl;
      repeat (len/2) @(posedge aclk);
      if (bph && f[i])
        lvl = !lvl;
      rxd <= lvl;
      repeat (len - len/2) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// *** bench/serial_port_rate_format_select_tb.sv ***
`timescale 1ns/100ps
`include "spr_regs.svh"
module serial_port_rate_format_select_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, txd, rxd, clk_oe, ext_ck;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp, rs2;
  logic [9:0]  fr;
  logic [7:0]  d;
  int          n_fail, checked, cyc, n;
  spr_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ser_txd(txd), .ser_rxd(rxd), .ser_clk_i(ext_ck), .ser_clk_o(),
    .ser_clk_oe(clk_oe));
  spr_far u_far (.aclk(aclk), .txd(txd), .rxd(rxd));
  // ==========================================
  function int dv(input int r);
    return r == 0 ? `SPR_DIV0 : r == 1 ? `SPR_DIV1 : r == 2 ? `SPR_DIV2 :
           r == 3 ? `SPR_DIV3 : `SPR_OVS * 8;
  endfunction
  task chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // each channel drops valid at the edge that takes it
  task automatic wr(input logic [31:0] a, dat, output logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // ==========================================
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  // remote bit clock: one rise every 8 bus cycles
  initial begin
    ext_ck = 0;
    forever begin
      repeat (4) @(posedge aclk);
      ext_ck <= ~ext_ck;
    end
  end
  // hang guard, sized well past the slowest rate sweep
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr} = 0;
    {n_fail, checked, cyc} = 0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(66732));
    rd(0, rd_v, rsp);
    chk("ctrl reset", rd_v, `SPR_CTRL_RESET);
    chk("idle line", txd, 1);
    rd(32'h10, rd_v, rsp);
    chk("bad read", {rd_v[29:0], rsp}, 2'b10);
    wr(32'h10, 32'h5, rsp);
    chk("bad write", rsp, 2'b10);
    $display("reset and map test done");
    // every format code; clock pin driven only for code 10
    for (int c = 0; c < 4; c++) begin
      wr(0, c << 2, rsp);
      rd(0, rd_v, rsp);
      chk("ctrl value", rd_v, c << 2);
      chk("clock pin drive", clk_oe, c == 2);
    end
    $display("format code test done");
    // start bit of an all-ones byte lasts exactly one divisor
    // code 4 here stands for the external clock option
    for (int r = 0; r < 5; r++) begin
      wr(0, r == 4 ? 32'hC : 4 | r, rsp);
      fork
        wr(`SPR_TXDATA_OFS, 32'hFF, rsp);
        begin
          @(negedge txd);
          n = 0;
          @(negedge aclk);
          while (!txd) begin
            n++;
            @(negedge aclk);
          end
        end
      join
      chk("start bit length", n, dv(r));
      repeat (10 * dv(r)) @(posedge aclk);
    end
    $display("rate test done");
    // nrz then biphase; format is switched mid-character and a busy write is dropped
    wr(0, 32'h4, rsp);
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? 8'h00 : i == 4 ? 8'hFF : 8'($urandom);
      fork
        wr(`SPR_TXDATA_OFS, d, rsp);
        u_far.recv(i > 2, fr);
        if (i == 2) begin
          repeat (40) @(posedge aclk);
          wr(`SPR_TXDATA_OFS, 32'h3C, rs2);
          wr(0, 32'h0, rs2);
        end
      join
      chk("tx frame", fr, {1'b1, d, 1'b0});
      repeat (8) @(posedge aclk);
    end
    $display("transmit test done");
    // receive nrz, biphase, and biphase from a remote clock running slow
    for (int k = 0; k < 3; k++) begin
      wr(0, k > 0 ? 0 : 4, rsp);
      d = 8'($urandom);
      u_far.send(k > 0, k == 2 ? 19 : 16, d);
      n = 0;
      do begin
        rd(`SPR_STATUS_OFS, rd_v, rsp);
        n++;
      end while (!rd_v[`SPR_ST_RX_FULL] && n < 40);
      rd(`SPR_RXDATA_OFS, rd_v, rsp);
      chk("rx byte", rd_v[7:0], d);
    end
    $display("receive test done");
    close_out();
  end
endmodule
